// ---- inc/tcr_pkg.sv ----
/*
 * constants, field layouts, reset values and timing counts of the
 * transceiver control register bank.
 * assumes a single 200 MHz clock and the register port of tcr_control_regs.
 */
package tcr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_LINE_STATUS  = 8'h02;
    localparam logic [7:0] ADDR_CONV_STATUS  = 8'h03;
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CURRENT_LIMIT_CONFIG = 8'h05;
    localparam logic [7:0] ADDR_IO_CONTROL   = 8'h06;

    // reset values
    localparam logic [7:0] MODE_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] CURRENT_LIMIT_RESET = 8'h00;
    localparam logic [7:0] IO_CONTROL_RESET    = 8'h00;

    // mode_control fields
    localparam int SOFT_RESET_BIT          = 7;
    localparam int HALF_DUPLEX_SELECT_BIT  = 6;
    localparam int PARALLEL_DRIVE_BIT      = 5;
    localparam int ANTIVALENT_BIT          = 4;
    localparam int CONV_DISCONTINUOUS_BIT  = 3;
    localparam int CONV_PULSE_SKIP_BIT     = 2;
    localparam int CONV_SPREAD_BIT         = 1;
    localparam int CONV_DISABLE_BIT        = 0;

    // current_limit_config fields
    localparam int CL_LEVEL_LSB            = 6;
    localparam int CL_DISABLE_BIT          = 5;
    localparam int BLANKING_LSB            = 3;
    localparam int RETRY_OFF_LSB           = 1;
    localparam int AUTO_RETRY_BIT          = 0;

    // io_control fields
    localparam int AUX_REG_DISABLE_BIT     = 7;
    localparam int WAKEUP_DISABLE_BIT      = 6;
    localparam int AUX_RX_DISABLE_BIT      = 5;
    localparam int AUX_RX_FILTER_BIT       = 4;
    localparam int RX_OUT_DISABLE_BIT      = 3;
    localparam int LINE_RX_FILTER_BIT      = 2;
    localparam int AUX_DRIVER_LEVEL_BIT    = 1;
    localparam int LINE_DRIVER_LEVEL_BIT   = 0;

    // status fields
    localparam int MAIN_LINE_LEVEL_BIT     = 7;
    localparam int AUX_LINE_LEVEL_BIT      = 6;
    localparam int CONV_FAULT_BIT          = 1;
    localparam int CONV_READY_BIT          = 0;

    // timing
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned FILTER_TIME_NS = 1000;
    localparam int unsigned FILTER_CYC     = FILTER_TIME_NS * CLK_MHZ / 1000;
    localparam int unsigned BLANK_US_0     = 128;
    localparam int unsigned BLANK_US_1     = 500;
    localparam int unsigned BLANK_US_2     = 1000;
    localparam int unsigned BLANK_US_3     = 5000;
    localparam int unsigned BLANK_CYC_0    = BLANK_US_0 * CLK_MHZ;
    localparam int unsigned BLANK_CYC_1    = BLANK_US_1 * CLK_MHZ;
    localparam int unsigned BLANK_CYC_2    = BLANK_US_2 * CLK_MHZ;
    localparam int unsigned BLANK_CYC_3    = BLANK_US_3 * CLK_MHZ;
    localparam int unsigned RETRY_MS_0     = 50;
    localparam int unsigned RETRY_MS_1     = 100;
    localparam int unsigned RETRY_MS_2     = 200;
    localparam int unsigned RETRY_MS_3     = 500;
    localparam int unsigned RETRY_CYC_0    = RETRY_MS_0 * 1000 * CLK_MHZ;
    localparam int unsigned RETRY_CYC_1    = RETRY_MS_1 * 1000 * CLK_MHZ;
    localparam int unsigned RETRY_CYC_2    = RETRY_MS_2 * 1000 * CLK_MHZ;
    localparam int unsigned RETRY_CYC_3    = RETRY_MS_3 * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        TCR_CONV_PWM,
        TCR_CONV_DCM,
        TCR_CONV_PFM
    } tcr_conv_mode_t;

endpackage : tcr_pkg

// ---- inc/tcr_flt_if.sv ----
/*
 * link between the register bank and one receiver glitch filter.
 * assumes the raw level is already synchronous to the clock.
 */
`timescale 1ns/1ps
interface tcr_flt_if;
    logic rawLevel;
    logic filterOn;
    logic cleanLevel;

    modport filt (input rawLevel, input filterOn, output cleanLevel);
    modport user (output rawLevel, output filterOn, input cleanLevel);
endinterface : tcr_flt_if

// ---- hdl/tcr_glitch_filter.sv ----
/*
 * counter-based glitch filter for one receiver.
 * assumes the raw level is synchronous to the clock.
 */
`timescale 1ns/1ps
module tcr_glitch_filter (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filter link
    tcr_flt_if.filt  flt
);
    typedef struct packed {
        logic [15:0] count;
        logic        level;
    } tcr_flt_state_t;

    tcr_flt_state_t st_q;
    tcr_flt_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (!flt.filterOn) begin
            st_d.count = 16'h0000;
            st_d.level = flt.rawLevel;
        end else if (flt.rawLevel == st_q.level) begin
            st_d.count = 16'h0000; // glitch shorter than the period is dropped
        end else if (st_q.count == 16'(tcr_pkg::FILTER_CYC - 1)) begin
            st_d.count = 16'h0000;
            st_d.level = flt.rawLevel;
        end else begin
            st_d.count = st_q.count + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flt.cleanLevel = st_q.level;
endmodule : tcr_glitch_filter

// ---- hdl/tcr_retry_timer.sv ----
/*
 * fault blanking and auto-retry off timer for one driver.
 * assumes the fault input is synchronous and the counts stay stable.
 */
`timescale 1ns/1ps
module tcr_retry_timer (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // settings
    input wire logic        retryEnable,
    input wire logic [31:0] blankCycles,
    input wire logic [31:0] offCycles,
    // driver
    input wire logic        faultIn,
    output logic            driverOn
);
    typedef enum logic {RT_WATCH, RT_OFF} tcr_rt_state_t;

    typedef struct packed {
        tcr_rt_state_t state;
        logic [31:0]   count;
        logic          on;
    } tcr_rt_t;

    tcr_rt_t st_q;
    tcr_rt_t st_d;

    always_comb begin
        st_d = st_q;
        unique case (st_q.state)
            RT_WATCH: begin
                st_d.on = 1'b1;
                if (!retryEnable || !faultIn) begin
                    st_d.count = 32'h0;
                end else if (st_q.count + 32'h1 >= blankCycles) begin
                    st_d.state = RT_OFF; // fault outlasted blanking
                    st_d.count = 32'h0;
                    st_d.on    = 1'b0;
                end else begin
                    st_d.count = st_q.count + 32'h1;
                end
            end
            RT_OFF: begin
                if (st_q.count + 32'h1 >= offCycles) begin
                    st_d.state = RT_WATCH; // re-enable after off time
                    st_d.count = 32'h0;
                    st_d.on    = 1'b1;
                end else begin
                    st_d.count = st_q.count + 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '{state: RT_WATCH, count: 32'h0, on: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign driverOn = st_q.on;
endmodule : tcr_retry_timer

// ---- hdl/tcr_control_regs.sv ----
/*
 * mode, current-limit and io control registers of the line transceiver,
 * with the driver steering, receiver gating and status they imply.
 * assumes a host serial interface that presents one-cycle read and
 * write strobes with an address, all synchronous to clock.
 */
`timescale 1ns/1ps
module tcr_control_regs #(
    parameter int unsigned BLANK_CYC_0 = tcr_pkg::BLANK_CYC_0,
    parameter int unsigned BLANK_CYC_1 = tcr_pkg::BLANK_CYC_1,
    parameter int unsigned BLANK_CYC_2 = tcr_pkg::BLANK_CYC_2,
    parameter int unsigned BLANK_CYC_3 = tcr_pkg::BLANK_CYC_3,
    parameter int unsigned RETRY_CYC_0 = tcr_pkg::RETRY_CYC_0,
    parameter int unsigned RETRY_CYC_1 = tcr_pkg::RETRY_CYC_1,
    parameter int unsigned RETRY_CYC_2 = tcr_pkg::RETRY_CYC_2,
    parameter int unsigned RETRY_CYC_3 = tcr_pkg::RETRY_CYC_3
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // register port from the host serial interface
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    // serial port
    output logic            sdoUnused,
    // line side inputs
    input  wire logic       txIn,
    input  wire logic       lineRxIn,
    input  wire logic       auxRxIn,
    input  wire logic       lineFault,
    input  wire logic       auxFault,
    // converter feedback
    input  wire logic       convSoftStartDone,
    input  wire logic       convSteady,
    input  wire logic       convFault,
    // driver controls
    output logic            lineDriveLevel,
    output logic            auxDriveLevel,
    output logic            lineDriverOn,
    output logic            auxDriverOn,
    output logic            currentLimitOn,
    output logic [1:0]      currentLimitLevel,
    output logic [1:0]      faultBlankingTime,
    // receiver pins
    output logic            rxOut,
    output logic            rxOeN,
    output logic            auxLogicPinOut,
    output logic            auxRxOn,
    // converter and supplies
    output logic            convOn,
    output tcr_pkg::tcr_conv_mode_t convMode,
    output logic            convSpread,
    output logic            auxRegulatorOn,
    output logic            wakeupDetectOn
);
    typedef struct packed {
        logic [7:0]               mode;
        logic [7:0]               climit;
        logic [7:0]               ioCtl;
        logic [7:0]               rdData;
        logic                     sdoOff;
        logic                     lineDrv;
        logic                     auxDrv;
        logic                     lineOn;
        logic                     auxOn;
        logic                     clOn;
        logic [1:0]               clLevel;
        logic [1:0]               blank;
        logic                     rx;
        logic                     rxOeN;
        logic                     auxLogic;
        logic                     auxRxOn;
        logic                     convOn;
        tcr_pkg::tcr_conv_mode_t  convMode;
        logic                     convSpread;
        logic                     auxRegOn;
        logic                     wakeOn;
    } tcr_regs_t;

    tcr_regs_t st_q;
    tcr_regs_t st_d;

    tcr_flt_if lineFlt ();
    tcr_flt_if auxFlt ();

    logic        lineOnRaw;
    logic        auxOnRaw;
    logic [31:0] blankCyc;
    logic [31:0] offCyc;
    logic        mainLineLevel;
    logic        auxLineLevel;
    logic        convReady;
    logic        lineSource;
    logic        autoRetry;

    function automatic logic [31:0] pickCycles(input logic [1:0]  sel,
                                               input logic [31:0] c0,
                                               input logic [31:0] c1,
                                               input logic [31:0] c2,
                                               input logic [31:0] c3);
        logic [31:0] r;
        unique case (sel)
            2'h0: r = c0;
            2'h1: r = c1;
            2'h2: r = c2;
            2'h3: r = c3;
        endcase
        return r;
    endfunction : pickCycles

    assign lineFlt.rawLevel = lineRxIn;
    assign lineFlt.filterOn = st_q.ioCtl[tcr_pkg::LINE_RX_FILTER_BIT];
    assign auxFlt.rawLevel  = auxRxIn;
    assign auxFlt.filterOn  = st_q.ioCtl[tcr_pkg::AUX_RX_FILTER_BIT];

    tcr_glitch_filter u_line_filter (
        .clock (clock),
        .rst_n (rst_n),
        .flt   (lineFlt.filt)
    );

    tcr_glitch_filter u_aux_filter (
        .clock (clock),
        .rst_n (rst_n),
        .flt   (auxFlt.filt)
    );

    assign autoRetry = st_q.climit[tcr_pkg::AUTO_RETRY_BIT];
    assign blankCyc  = pickCycles(st_q.climit[tcr_pkg::BLANKING_LSB +: 2],
                                  32'(BLANK_CYC_0), 32'(BLANK_CYC_1),
                                  32'(BLANK_CYC_2), 32'(BLANK_CYC_3));
    assign offCyc    = pickCycles(st_q.climit[tcr_pkg::RETRY_OFF_LSB +: 2],
                                  32'(RETRY_CYC_0), 32'(RETRY_CYC_1),
                                  32'(RETRY_CYC_2), 32'(RETRY_CYC_3));

    tcr_retry_timer u_line_retry (
        .clock       (clock),
        .rst_n       (rst_n),
        .retryEnable (autoRetry),
        .blankCycles (blankCyc),
        .offCycles   (offCyc),
        .faultIn     (lineFault),
        .driverOn    (lineOnRaw)
    );

    tcr_retry_timer u_aux_retry (
        .clock       (clock),
        .rst_n       (rst_n),
        .retryEnable (autoRetry),
        .blankCycles (blankCyc),
        .offCycles   (offCyc),
        .faultIn     (auxFault),
        .driverOn    (auxOnRaw)
    );

    // status reads: a set level bit means the line is low
    assign mainLineLevel = !st_q.ioCtl[tcr_pkg::RX_OUT_DISABLE_BIT]
                           && !lineFlt.cleanLevel;
    assign auxLineLevel  = !st_q.ioCtl[tcr_pkg::AUX_RX_DISABLE_BIT]
                           && !auxFlt.cleanLevel;
    // disabled converter reports ready so software polling does not stall
    assign convReady = st_q.mode[tcr_pkg::CONV_DISABLE_BIT]
                       || (convSteady && !convFault);
    assign lineSource = txIn | st_q.ioCtl[tcr_pkg::LINE_DRIVER_LEVEL_BIT];

    always_comb begin
        st_d = st_q;

        // register writes
        if (regWrEn) begin
            unique case (regAddr)
                tcr_pkg::ADDR_MODE_CONTROL: begin
                    if (regWrData[tcr_pkg::SOFT_RESET_BIT]) begin
                        // soft reset is never stored, so it reads back zero
                        st_d.mode   = tcr_pkg::MODE_CONTROL_RESET;
                        st_d.climit = tcr_pkg::CURRENT_LIMIT_RESET;
                        st_d.ioCtl  = tcr_pkg::IO_CONTROL_RESET;
                    end else begin
                        st_d.mode = regWrData;
                    end
                end
                tcr_pkg::ADDR_CURRENT_LIMIT_CONFIG: st_d.climit = regWrData;
                tcr_pkg::ADDR_IO_CONTROL:           st_d.ioCtl  = regWrData;
                default: ;
            endcase
        end

        // register reads, unmapped offsets answer zero
        if (regRdEn) begin
            st_d.rdData = 8'h00;
            unique case (regAddr)
                tcr_pkg::ADDR_LINE_STATUS: begin
                    st_d.rdData[tcr_pkg::MAIN_LINE_LEVEL_BIT] = mainLineLevel;
                    st_d.rdData[tcr_pkg::AUX_LINE_LEVEL_BIT]  = auxLineLevel;
                end
                tcr_pkg::ADDR_CONV_STATUS: begin
                    st_d.rdData[tcr_pkg::CONV_FAULT_BIT] = convFault;
                    st_d.rdData[tcr_pkg::CONV_READY_BIT] = convReady;
                end
                tcr_pkg::ADDR_MODE_CONTROL:         st_d.rdData = st_q.mode;
                tcr_pkg::ADDR_CURRENT_LIMIT_CONFIG: st_d.rdData = st_q.climit;
                tcr_pkg::ADDR_IO_CONTROL:           st_d.rdData = st_q.ioCtl;
                default:                            st_d.rdData = 8'h00;
            endcase
        end

        // serial port form
        st_d.sdoOff = st_q.mode[tcr_pkg::HALF_DUPLEX_SELECT_BIT];

        // driver levels
        st_d.lineDrv = lineSource;
        if (!st_q.mode[tcr_pkg::PARALLEL_DRIVE_BIT]) begin
            st_d.auxDrv = st_q.ioCtl[tcr_pkg::AUX_DRIVER_LEVEL_BIT];
        end else if (st_q.mode[tcr_pkg::ANTIVALENT_BIT]) begin
            st_d.auxDrv = !lineSource;
        end else begin
            st_d.auxDrv = lineSource;
        end
        st_d.lineOn = lineOnRaw;
        st_d.auxOn  = auxOnRaw;

        // current limit
        st_d.clOn    = !st_q.climit[tcr_pkg::CL_DISABLE_BIT];
        st_d.clLevel = st_q.climit[tcr_pkg::CL_LEVEL_LSB +: 2];
        st_d.blank   = st_q.climit[tcr_pkg::BLANKING_LSB +: 2];

        // receivers
        st_d.rxOeN    = st_q.ioCtl[tcr_pkg::RX_OUT_DISABLE_BIT];
        st_d.rx       = lineFlt.cleanLevel;
        st_d.auxRxOn  = !st_q.ioCtl[tcr_pkg::AUX_RX_DISABLE_BIT];
        st_d.auxLogic = !st_q.ioCtl[tcr_pkg::AUX_RX_DISABLE_BIT]
                        && auxFlt.cleanLevel;

        // converter: mode applies only once soft-start has finished
        st_d.convOn = !st_q.mode[tcr_pkg::CONV_DISABLE_BIT];
        if (!convSoftStartDone) begin
            st_d.convMode = tcr_pkg::TCR_CONV_PWM;
        end else if (st_q.mode[tcr_pkg::CONV_PULSE_SKIP_BIT]) begin
            st_d.convMode = tcr_pkg::TCR_CONV_PFM;
        end else if (st_q.mode[tcr_pkg::CONV_DISCONTINUOUS_BIT]) begin
            st_d.convMode = tcr_pkg::TCR_CONV_DCM;
        end else begin
            st_d.convMode = tcr_pkg::TCR_CONV_PWM;
        end
        st_d.convSpread = st_q.mode[tcr_pkg::CONV_SPREAD_BIT];

        // supplies and wake-up
        st_d.auxRegOn = !st_q.ioCtl[tcr_pkg::AUX_REG_DISABLE_BIT];
        st_d.wakeOn   = !st_q.ioCtl[tcr_pkg::WAKEUP_DISABLE_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q          <= '0;
            st_q.mode     <= tcr_pkg::MODE_CONTROL_RESET;
            st_q.climit   <= tcr_pkg::CURRENT_LIMIT_RESET;
            st_q.ioCtl    <= tcr_pkg::IO_CONTROL_RESET;
            st_q.lineOn   <= 1'b1;
            st_q.auxOn    <= 1'b1;
            st_q.clOn     <= 1'b1;
            st_q.auxRxOn  <= 1'b1;
            st_q.convOn   <= 1'b1;
            st_q.convMode <= tcr_pkg::TCR_CONV_PWM;
            st_q.auxRegOn <= 1'b1;
            st_q.wakeOn   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign regRdData         = st_q.rdData;
    assign sdoUnused         = st_q.sdoOff;
    assign lineDriveLevel    = st_q.lineDrv;
    assign auxDriveLevel     = st_q.auxDrv;
    assign lineDriverOn      = st_q.lineOn;
    assign auxDriverOn       = st_q.auxOn;
    assign currentLimitOn    = st_q.clOn;
    assign currentLimitLevel = st_q.clLevel;
    assign faultBlankingTime = st_q.blank;
    assign rxOut             = st_q.rx;
    assign rxOeN             = st_q.rxOeN;
    assign auxLogicPinOut    = st_q.auxLogic;
    assign auxRxOn           = st_q.auxRxOn;
    assign convOn            = st_q.convOn;
    assign convMode          = st_q.convMode;
    assign convSpread        = st_q.convSpread;
    assign auxRegulatorOn    = st_q.auxRegOn;
    assign wakeupDetectOn    = st_q.wakeOn;
endmodule : tcr_control_regs

// ---- verif/tcr_regs_checker.sv ----
/* assertions on the ports of tcr_control_regs.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module tcr_regs_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    // controls
    input wire logic       sdoUnused,
    input wire logic       txIn,
    input wire logic       convSoftStartDone,
    input wire logic       lineDriveLevel,
    input wire logic       currentLimitOn,
    input wire logic [1:0] currentLimitLevel,
    input wire logic [1:0] faultBlankingTime,
    input wire logic       rxOeN,
    input wire logic       auxLogicPinOut,
    input wire logic       auxRxOn,
    input wire logic       convOn,
    input wire logic       convSpread,
    input tcr_pkg::tcr_conv_mode_t convMode
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wr(logic [7:0] a, logic [7:0] m, logic [7:0] v);
        regWrEn && regAddr == a && (regWrData & m) == v;
    endsequence
    // a quiet cycle keeps a following write from masking the effect
    sequence s_quiet;
        !regWrEn;
    endsequence
    a_half_duplex: assert property (s_wr(8'h04, 8'hc0, 8'h40) ##1 s_quiet |=> sdoUnused)
        else $error("half duplex not shown");
    a_conv_disable: assert property (s_wr(8'h04, 8'h81, 8'h01) ##1 s_quiet |=> !convOn)
        else $error("converter still on");
    a_rx_hiz: assert property (s_wr(8'h06, 8'h08, 8'h08) ##1 s_quiet |=> rxOeN)
        else $error("receive output still driven");
    a_aux_rx_off: assert property (s_wr(8'h06, 8'h20, 8'h20) ##1 s_quiet |=> !auxRxOn)
        else $error("aux receiver still on");
    a_aux_pin_low: assert property (!auxRxOn [*3] |-> !auxLogicPinOut)
        else $error("aux pin high while receiver off");
    a_soft_reset: assert property (s_wr(8'h04, 8'h80, 8'h80) |-> ##2 (convOn && !convSpread
        && !sdoUnused && !rxOeN && currentLimitOn))
        else $error("soft reset left settings");
    a_limit_fields: assert property (s_wr(8'h05, 8'h00, 8'h00) ##1 s_quiet |=>
        currentLimitLevel == $past(regWrData[7:6], 2) && currentLimitOn == !$past(regWrData[5], 2)
        && faultBlankingTime == $past(regWrData[4:3], 2))
        else $error("limit fields wrong");
    a_pwm_first: assert property (!convSoftStartDone [*2] |-> convMode == tcr_pkg::TCR_CONV_PWM)
        else $error("mode before soft start");
    a_tx_drive: assert property ($past(rst_n) && $past(txIn) |-> lineDriveLevel)
        else $error("line drive ignores transmit");
    a_rd_unmapped: assert property (regRdEn && (regAddr < 8'h02 || regAddr > 8'h06)
        |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved");
endmodule : tcr_regs_checker

// ---- verif/tb_top.sv ----
/* self-checking bench of tcr_control_regs with shortened timer counts.
   assumes the checker file is compiled before this one. */
`timescale 1ns/1ps
module tb_top;
    logic       clock = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, txIn = 0;
    logic       lineRxIn = 0, auxRxIn = 0, lineFault = 0, auxFault = 0;
    logic       convSoftStartDone = 0, convSteady = 1, convFault = 0;
    logic [7:0] regAddr = 0, regWrData = 0, regRdData, rv, mcr, lim, ioc;
    logic       sdoUnused, lineDriveLevel, auxDriveLevel, lineDriverOn, auxDriverOn;
    logic       currentLimitOn, rxOut, rxOeN, auxLogicPinOut, auxRxOn, convOn;
    logic       convSpread, auxRegulatorOn, wakeupDetectOn;
    logic [1:0] currentLimitLevel, faultBlankingTime;
    tcr_pkg::tcr_conv_mode_t convMode;
    int         mismatches = 0, n_checks = 0, cyc = 0, n;
    int         off[4] = '{40, 60, 80, 100};
    logic [7:0] cm[6] = '{8'h30, 8'h10, 8'h20, 8'h0c, 8'h08, 8'h41};
    // only the shortest blanking is shortened; wider blanking codes are checked as fields
    tcr_control_regs #(.BLANK_CYC_0(8), .RETRY_CYC_0(40), .RETRY_CYC_1(60),
        .RETRY_CYC_2(80), .RETRY_CYC_3(100)) tcr_control_regs_i (.*);
    always #2.5 clock = ~clock;
    // a hang ends the run as a failure
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        {regWrEn, regAddr, regWrData} = {1'b1, a, d};
        @(negedge clock);
        regWrEn = 0;
    endtask : wr
    task automatic rd(logic [7:0] a);
        @(negedge clock);
        {regRdEn, regAddr} = {1'b1, a};
        @(negedge clock);
        regRdEn = 0;
        rv = regRdData;
    endtask : rd
    function automatic logic [15:0] expo(logic [7:0] m, logic [7:0] c, logic [7:0] i, logic t);
        logic       aux;
        logic [1:0] cv;
        aux = m[5] ? ((t | i[0]) ^ m[4]) : i[1];
        cv = m[2] ? tcr_pkg::TCR_CONV_PFM : (m[3] ? tcr_pkg::TCR_CONV_DCM : tcr_pkg::TCR_CONV_PWM);
        return {m[6], !m[0], m[1], !c[5], c[7:6], c[4:3], i[3], !i[5], !i[7], !i[6], t | i[0], aux, cv};
    endfunction : expo
    function automatic logic [15:0] obs();
        return {sdoUnused, convOn, convSpread, currentLimitOn, currentLimitLevel, faultBlankingTime,
            rxOeN, auxRxOn, auxRegulatorOn, wakeupDetectOn, lineDriveLevel, auxDriveLevel, convMode};
    endfunction : obs
    initial begin
        void'($urandom(28672));
        repeat (2) @(negedge clock);
        rst_n = 1;
        for (int a = 4; a < 7; a++) begin
            rd(8'(a));
            chk("reset value", 16'h0, {8'h0, rv});
        end
        rd(8'h03);
        chk("conv status", 16'h1, {8'h0, rv});
        convSoftStartDone = 1;
        for (int k = 0; k < 24; k++) begin
            mcr = k < 6 ? cm[k] : 8'($urandom) & 8'h7f;
            if (k >= 6 && mcr[4]) mcr[5] = 1'b1;
            lim = 8'($urandom);
            ioc = 8'($urandom);
            txIn = 1'($urandom);
            wr(8'h04, mcr);
            wr(8'h05, lim);
            wr(8'h06, ioc);
            @(negedge clock);
            chk("outputs", expo(mcr, lim, ioc, txIn), obs());
            rd(8'h04);
            chk("mode_control", {8'h0, mcr}, {8'h0, rv});
            rd(8'h05);
            chk("current_limit_config", {8'h0, lim}, {8'h0, rv});
            rd(8'h06);
            chk("io_control", {8'h0, ioc}, {8'h0, rv});
        end
        wr(8'h04, 8'hff);
        for (int a = 4; a < 7; a++) begin
            rd(8'(a));
            chk("soft reset", 16'h0, {8'h0, rv});
        end
        chk("outputs", expo(8'h0, 8'h0, 8'h0, txIn), obs());
        wr(8'h07, 8'h5a);
        rd(8'h07);
        chk("unmapped", 16'h0, {8'h0, rv});
        convSteady = 0;
        wr(8'h04, 8'h01);
        repeat (3) @(negedge clock);
        rd(8'h03);
        chk("conv status", 16'h1, {8'h0, rv});
        wr(8'h04, 8'h00);
        {convSteady, convFault} = 2'b11;
        repeat (3) @(negedge clock);
        rd(8'h03);
        chk("conv status", 16'h2, {8'h0, rv});
        convFault = 0;
        rd(8'h02);
        chk("line status", 16'hc0, {8'h0, rv});
        wr(8'h06, 8'h28);
        repeat (5) @(negedge clock);
        rd(8'h02);
        chk("line status", 16'h0, {8'h0, rv});
        // glitch shorter than the filter period must not pass
        wr(8'h06, 8'h14);
        {lineRxIn, auxRxIn} = 2'b11;
        repeat (100) @(negedge clock);
        {lineRxIn, auxRxIn} = 2'b00;
        repeat (250) @(negedge clock);
        chk("filtered", 16'h0, {14'h0, rxOut, auxLogicPinOut});
        {lineRxIn, auxRxIn} = 2'b11;
        repeat (250) @(negedge clock);
        chk("filtered", 16'h3, {14'h0, rxOut, auxLogicPinOut});
        wr(8'h06, 8'h00);
        {lineRxIn, auxRxIn} = 2'b00;
        repeat (4) @(negedge clock);
        chk("unfiltered", 16'h0, {14'h0, rxOut, auxLogicPinOut});
        for (int t = 0; t < 4; t++) begin
            wr(8'h05, 8'(t * 2 + 1));
            {lineFault, auxFault} = 2'b11;
            repeat (5) @(negedge clock);
            {lineFault, auxFault} = 2'b00;
            repeat (3) @(negedge clock);
            chk("driver on", 16'h3, {14'h0, lineDriverOn, auxDriverOn});
            {lineFault, auxFault} = 2'b11;
            n = 0;
            while (lineDriverOn === 1'b1 && n < 200) begin
                @(negedge clock);
                n++;
            end
            {lineFault, auxFault} = 2'b00;
            chk("blanking", 16'h1, {15'h0, n >= 8 && n <= 11});
            n = 0;
            while (lineDriverOn !== 1'b1 && n < 200) begin
                @(negedge clock);
                n++;
            end
            chk("off time", 16'(off[t]), 16'(n));
        end
        wr(8'h05, 8'h00);
        {lineFault, auxFault} = 2'b11;
        repeat (60) @(negedge clock);
        chk("no retry", 16'h3, {14'h0, lineDriverOn, auxDriverOn});
        stop_test();
    end
endmodule : tb_top
bind tcr_control_regs tcr_regs_checker tcr_regs_checker_i (.*);
